//--- sst_sequencer.sv
/*
  Stored setpoint sequencer: keypad entry over Wishbone, 100-location store,
  step/one-pass/looping sequencer, operate gating and external triggers.
  Assumes a classic Wishbone master on mclk and an asynchronous trigger pin.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sst_consts.svh"
module sst_sequencer
  import sst_pkg::*;
#(
  parameter int NLOC = 100,
  parameter int CLK_KHZ = `SST_CLK_KHZ,
  parameter int TEST_CYC = `SST_TEST_MS * `SST_CLK_KHZ,
  parameter int SHOW_CYC = `SST_SHOW_MS * `SST_CLK_KHZ,
  parameter int MS_CYC = `SST_CLK_KHZ,
  parameter logic [7:0] FW_REV = 8'h2a,
  parameter logic [7:0] BUS_ADDR = 8'h0c
)(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_trig_in_n,
  output logic ext_trig_out_n,
  output sst_sp_t out_sp,
  output logic [6:0] out_vl,
  output sst_lamp_t lamp
);
  localparam int LW = $clog2(NLOC);
  localparam int TRIG_CYC = (`SST_TRIG_US * CLK_KHZ + 999) / 1000;

  // Sizes the logic cannot serve
  if (NLOC < 2 || NLOC > 128 || TRIG_CYC > 60000 || MS_CYC < 2)
  begin : g_chk
    $error("sst_sequencer: unsupported parameter values");
  end

  logic wb_ack_reg;
  logic [31:0] wb_dat_reg;
  sst_phase_t phase_reg;
  logic [31:0] ph_cnt_reg;
  sst_disp_t disp_reg;
  sst_norm_t norm_reg;
  sst_pmode_t mode_reg;
  logic operate_reg;
  logic ent_act_reg, ent_dot_reg, ent_expk_reg, ent_neg_reg, ent_eneg_reg;
  logic [23:0] ent_mant_reg;
  logic [3:0] ent_edig_reg;
  logic signed [5:0] ent_adj_reg;
  logic [23:0] w_mant_reg;
  logic signed [5:0] w_exp_reg;
  logic w_neg_reg;
  logic cm_sp_reg, cm_vl_reg, cm_dw_reg, cm_loc_reg;
  logic [23:0] cm_val_reg;
  sst_sp_t cm_spv_reg;
  logic [31:0] err_cnt_reg;
  sst_sp_t sp_mem [NLOC];
  logic [6:0] vl_mem [NLOC];
  logic [19:0] dw_mem [NLOC];
  logic [LW-1:0] loc_reg;
  logic run_reg;
  logic [19:0] dw_left_reg;
  logic [31:0] pre_reg;
  logic [15:0] trig_cnt_reg, lo_cnt_reg;
  logic ti_s1_reg, ti_s2_reg, trig_fire_reg, trig_out_n_reg;
  sst_sp_t out_sp_reg;
  logic [6:0] out_vl_reg;
  sst_lamp_t lamp_reg;

  // Key decode from a write to the key register
  logic wb_hit, key_go, is_digit, e_key, start_ev, err_on;
  logic [4:0] key;
  logic [23:0] m_base, rnd_rem, rnd;
  logic signed [5:0] ent_exp;
  logic [LW-1:0] nxt_loc, adv_loc;
  logic at_end, seq_wrap;
  logic [31:0] disp_val;
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
  assign key = wb_dat_i[4:0];
  assign err_on = (err_cnt_reg != 32'h0);
  assign key_go = wb_hit & wb_we_i & wb_sel_i[0] & (wb_adr_i == `SST_KEY_OFS)
                  & (phase_reg == PH_READY) & (norm_reg == NM_IDLE) & ~err_on;
  assign is_digit = (key <= 5'h09);
  assign e_key = key_go & (is_digit | key == `SST_K_DOT | key == `SST_K_MINUS
                 | (key == `SST_K_EXP & (disp_reg == DM_SRC | disp_reg == DM_DWELL)));
  assign m_base = ent_act_reg ? ent_mant_reg : 24'h0;
  assign ent_exp = ent_eneg_reg ? ent_adj_reg - $signed({2'b00, ent_edig_reg})
                                : ent_adj_reg + $signed({2'b00, ent_edig_reg});
  assign rnd_rem = w_mant_reg % 24'd10;
  assign rnd = w_mant_reg - rnd_rem + ((rnd_rem >= 24'd5) ? 24'd5 : 24'd0);
  assign start_ev = (key_go && key == `SST_K_RUN) || (trig_fire_reg && phase_reg == PH_READY);

  // Power-up lamp test, revision and address display
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_reg <= PH_TEST;
      ph_cnt_reg <= 32'h0;
    end
    else if (phase_reg != PH_READY)
    begin
      ph_cnt_reg <= ph_cnt_reg + 32'h1;
      if (ph_cnt_reg == 32'((phase_reg == PH_TEST) ? TEST_CYC - 1 : SHOW_CYC - 1))
      begin
        ph_cnt_reg <= 32'h0;
        phase_reg <= (phase_reg == PH_TEST) ? PH_REV : (phase_reg == PH_REV) ? PH_ADDR : PH_READY;
      end
    end
  end

  // Keypad entry, commit and normalisation
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      disp_reg <= DM_SRC;
      norm_reg <= NM_IDLE;
      ent_act_reg <= 1'b0;
      ent_dot_reg <= 1'b0;
      ent_expk_reg <= 1'b0;
      ent_neg_reg <= 1'b0;
      ent_eneg_reg <= 1'b0;
      ent_mant_reg <= 24'h0;
      ent_edig_reg <= 4'h0;
      ent_adj_reg <= 6'sd0;
      w_mant_reg <= 24'h0;
      w_exp_reg <= 6'sd0;
      w_neg_reg <= 1'b0;
      {cm_sp_reg, cm_vl_reg, cm_dw_reg, cm_loc_reg} <= 4'h0;
      cm_val_reg <= 24'h0;
      cm_spv_reg <= '0;
      err_cnt_reg <= 32'h0;
    end
    else
    begin
      {cm_sp_reg, cm_vl_reg, cm_dw_reg, cm_loc_reg} <= 4'h0;
      if (err_on)
        err_cnt_reg <= err_cnt_reg - 32'h1;
      case (norm_reg)
        NM_SP:
        begin
          if (w_mant_reg > `SST_MANT_HI)
          begin
            w_mant_reg <= w_mant_reg / 24'd10;
            w_exp_reg <= w_exp_reg + 6'sd1;
          end
          else if (w_mant_reg != 24'h0 && w_mant_reg < `SST_MANT_LO)
          begin
            w_mant_reg <= w_mant_reg * 24'd10;
            w_exp_reg <= w_exp_reg - 6'sd1;
          end
          else
          begin
            norm_reg <= NM_IDLE;
            if (rnd != 24'h0 && (w_exp_reg > `SST_SP_EXP_TOP
                || (w_exp_reg == `SST_SP_EXP_TOP && rnd > `SST_SP_MAX)))
              err_cnt_reg <= 32'(SHOW_CYC);
            else
            begin
              cm_sp_reg <= 1'b1;
              cm_spv_reg <= '{neg: w_neg_reg & (rnd != 24'h0),
                              exp: (rnd == 24'h0) ? 6'sd0 : w_exp_reg, mant: rnd[16:0]};
            end
          end
        end
        NM_DW:
        begin
          if (w_exp_reg < `SST_DW_EXP)
          begin
            w_mant_reg <= w_mant_reg / 24'd10;
            w_exp_reg <= w_exp_reg + 6'sd1;
          end
          else if (w_exp_reg > `SST_DW_EXP && w_mant_reg <= `SST_DW_MAX)
          begin
            w_mant_reg <= w_mant_reg * 24'd10;
            w_exp_reg <= w_exp_reg - 6'sd1;
          end
          else
          begin
            norm_reg <= NM_IDLE;
            if (w_exp_reg != `SST_DW_EXP || w_neg_reg || (w_mant_reg != 24'h0
                && (w_mant_reg < `SST_DW_MIN || w_mant_reg > `SST_DW_MAX)))
              err_cnt_reg <= 32'(SHOW_CYC);
            else
            begin
              cm_dw_reg <= 1'b1;
              cm_val_reg <= w_mant_reg;
            end
          end
        end
        default:
        begin
          if (key_go && key == `SST_K_RESET)
            ent_act_reg <= 1'b0;
          else if (e_key)
          begin
            ent_act_reg <= 1'b1;
            if (!ent_act_reg)
            begin
              {ent_dot_reg, ent_expk_reg, ent_eneg_reg} <= 3'h0;
              ent_neg_reg <= 1'b0;
              ent_mant_reg <= 24'h0;
              ent_edig_reg <= 4'h0;
              ent_adj_reg <= 6'sd0;
            end
            if (is_digit && ent_act_reg && ent_expk_reg)
              ent_edig_reg <= key[3:0];
            else if (is_digit && m_base < 24'd1000000)
            begin
              ent_mant_reg <= m_base * 24'd10 + {19'h0, key};
              if (ent_act_reg && ent_dot_reg)
                ent_adj_reg <= ent_adj_reg - 6'sd1;
            end
            else if (key == `SST_K_DOT)
              ent_dot_reg <= 1'b1;
            else if (key == `SST_K_MINUS && ent_act_reg && ent_expk_reg)
              ent_eneg_reg <= ~ent_eneg_reg;
            else if (key == `SST_K_MINUS)
              ent_neg_reg <= ~(ent_act_reg & ent_neg_reg);
            else if (key == `SST_K_EXP)
              ent_expk_reg <= 1'b1;
          end
          else if (key_go && key >= `SST_K_SRC && key <= `SST_K_MEM)
          begin
            ent_act_reg <= 1'b0;
            disp_reg <= sst_disp_t'(key[1:0]);
          end
          else if (key_go && key == `SST_K_ENTER && ent_act_reg)
          begin
            ent_act_reg <= 1'b0;
            w_mant_reg <= ent_mant_reg;
            w_exp_reg <= ent_exp;
            w_neg_reg <= ent_neg_reg;
            case (disp_reg)
              DM_SRC: norm_reg <= NM_SP;
              DM_DWELL: norm_reg <= NM_DW;
              DM_VLIM:
              begin
                if (!ent_neg_reg && ent_mant_reg != 24'h0 && ent_mant_reg <= `SST_VL_MAX)
                  cm_vl_reg <= 1'b1;
                else
                  err_cnt_reg <= 32'(SHOW_CYC);
                cm_val_reg <= ent_mant_reg;
              end
              default:
              begin
                if (!ent_neg_reg && ent_mant_reg != 24'h0 && ent_mant_reg <= 24'(NLOC))
                  cm_loc_reg <= 1'b1;
                else
                  err_cnt_reg <= 32'(SHOW_CYC);
                cm_val_reg <= ent_mant_reg - 24'h1;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Location store; cleared to defaults at reset
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NLOC; i++)
      begin
        sp_mem[i] <= '0;
        vl_mem[i] <= `SST_VL_RST;
        dw_mem[i] <= (i == 0) ? `SST_DW1_RST : 20'h0;
      end
    end
    else
    begin
      if (cm_sp_reg)
        sp_mem[loc_reg] <= cm_spv_reg;
      if (cm_vl_reg)
        vl_mem[loc_reg] <= cm_val_reg[6:0];
      if (cm_dw_reg)
        dw_mem[loc_reg] <= cm_val_reg[19:0];
      if (key_go && key == `SST_K_COPY && disp_reg == DM_MEM && !at_end)
      begin
        sp_mem[nxt_loc] <= sp_mem[loc_reg];
        vl_mem[nxt_loc] <= vl_mem[loc_reg];
        dw_mem[nxt_loc] <= dw_mem[loc_reg];
      end
    end
  end

  // Program mode and operate toggle
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_reg <= PM_STEP;
      operate_reg <= 1'b0;
    end
    else if (key_go)
    begin
      if (key == `SST_K_STEP)
        mode_reg <= PM_STEP;
      else if (key == `SST_K_SINGLE)
        mode_reg <= PM_SINGLE;
      else if (key == `SST_K_CONT)
        mode_reg <= PM_CONT;
      else if (key == `SST_K_OPER)
        operate_reg <= ~operate_reg;
    end
  end

  // Next location, with wrap on the last or a zero hold
  assign at_end = (loc_reg == LW'(NLOC - 1));
  assign nxt_loc = at_end ? '0 : loc_reg + LW'(1);
  assign seq_wrap = at_end || (dw_mem[nxt_loc] == 20'h0);
  assign adv_loc = seq_wrap ? '0 : nxt_loc;

  // Sequencer: pointer, hold timing and trigger pulse
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      loc_reg <= '0;
      run_reg <= 1'b0;
      dw_left_reg <= 20'h0;
      pre_reg <= 32'h0;
      trig_cnt_reg <= 16'h0;
    end
    else
    begin
      if (trig_cnt_reg != 16'h0)
        trig_cnt_reg <= trig_cnt_reg - 16'h1;
      if (run_reg && pre_reg != 32'h0)
        pre_reg <= pre_reg - 32'h1;
      if (key_go && key == `SST_K_RESET)
      begin
        loc_reg <= '0;
        run_reg <= 1'b0;
      end
      else if (cm_loc_reg)
        loc_reg <= cm_val_reg[LW-1:0];
      else if (start_ev && run_reg && mode_reg != PM_STEP)
        run_reg <= 1'b0;
      else if (start_ev && !run_reg)
      begin
        run_reg <= 1'b1;
        dw_left_reg <= dw_mem[loc_reg];
        pre_reg <= 32'(MS_CYC - 1);
      end
      else if (run_reg && pre_reg == 32'h0)
      begin
        if (dw_left_reg > 20'h1)
        begin
          dw_left_reg <= dw_left_reg - 20'h1;
          pre_reg <= 32'(MS_CYC - 1);
        end
        else
        begin
          trig_cnt_reg <= 16'(TRIG_CYC + 1);
          if (mode_reg == PM_STEP)
          begin
            run_reg <= 1'b0;
            loc_reg <= adv_loc;
          end
          else if (mode_reg == PM_SINGLE && seq_wrap)
            run_reg <= 1'b0;
          else
          begin
            loc_reg <= adv_loc;
            dw_left_reg <= dw_mem[adv_loc];
            pre_reg <= 32'(MS_CYC - 1);
          end
        end
      end
    end
  end

  // External trigger input: synchronise, then qualify low time
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ti_s1_reg <= 1'b1;
      ti_s2_reg <= 1'b1;
      lo_cnt_reg <= 16'(TRIG_CYC);
      trig_fire_reg <= 1'b0;
    end
    else
    begin
      ti_s1_reg <= ext_trig_in_n;
      ti_s2_reg <= ti_s1_reg;
      if (ti_s2_reg)
        lo_cnt_reg <= 16'h0;
      else if (lo_cnt_reg != 16'(TRIG_CYC))
        lo_cnt_reg <= lo_cnt_reg + 16'h1;
      trig_fire_reg <= !ti_s2_reg && lo_cnt_reg == 16'(TRIG_CYC - 1);
    end
  end

  // Output setpoint, compliance, lamps and trigger pin
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_sp_reg <= '0;
      out_vl_reg <= `SST_VL_RST;
      lamp_reg <= '0;
      trig_out_n_reg <= 1'b1;
    end
    else
    begin
      out_sp_reg <= operate_reg ? sp_mem[loc_reg] : '0;
      out_vl_reg <= (!operate_reg && vl_mem[loc_reg] > `SST_VL_CLAMP)
                    ? `SST_VL_CLAMP : vl_mem[loc_reg];
      lamp_reg <= (phase_reg == PH_TEST) ? '1 : sst_lamp_t'{operate: operate_reg,
                  step: mode_reg == PM_STEP, single: mode_reg == PM_SINGLE,
                  cont: mode_reg == PM_CONT, run: run_reg, err: err_on};
      trig_out_n_reg <= (trig_cnt_reg == 16'h0);
    end
  end

  // Shown value per display mode
  always_comb
  begin
    disp_val = 32'h0;
    if (phase_reg == PH_TEST)
      disp_val = 32'hffff_ffff;
    else if (phase_reg == PH_REV)
      disp_val = {24'h0, FW_REV};
    else if (phase_reg == PH_ADDR)
      disp_val = {24'h0, BUS_ADDR};
    else if (ent_act_reg)
      disp_val = {ent_neg_reg, ent_eneg_reg, 2'h0, ent_edig_reg, ent_mant_reg};
    else
      case (disp_reg)
        DM_SRC: disp_val = {8'h0, sp_mem[loc_reg]};
        DM_VLIM: disp_val = {25'h0, vl_mem[loc_reg]};
        DM_DWELL: disp_val = {dw_mem[loc_reg] > 20'h04e1f, 11'h0, dw_mem[loc_reg]};
        default: disp_val = {24'h0, 8'(loc_reg) + 8'h01};
      endcase
  end

  // Wishbone slave: one wait state, unmapped reads give zero
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0;
    end
    else
    begin
      wb_ack_reg <= wb_hit;
      if (wb_hit && !wb_we_i)
        case (wb_adr_i)
          `SST_KEY_OFS: wb_dat_reg <= {18'h0, phase_reg, norm_reg != NM_IDLE,
                                       ent_act_reg, disp_reg, mode_reg, lamp_reg};
          `SST_DISP_OFS: wb_dat_reg <= disp_val;
          `SST_OUT_OFS: wb_dat_reg <= {8'h0, out_sp_reg};
          `SST_LOC_OFS: wb_dat_reg <= {9'h0, out_vl_reg, 8'h0, 8'(loc_reg) + 8'h01};
          default: wb_dat_reg <= 32'h0;
        endcase
    end
  end

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;
  assign out_sp = out_sp_reg;
  assign out_vl = out_vl_reg;
  assign lamp = lamp_reg;
  assign ext_trig_out_n = trig_out_n_reg;

  // Checks
  logic [15:0] low_len_reg;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      low_len_reg <= 16'h0;
    else
      low_len_reg <= trig_out_n_reg ? 16'h0 : low_len_reg + 16'h1;
  end
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!rstn);
  out_zero_a: assert property (!operate_reg |=> out_sp == '0)
    else $error("output not zero outside operate");
  vl_clamp_a: assert property (!operate_reg && vl_mem[loc_reg] > 7'h20 |=> out_vl == 7'h20)
    else $error("compliance not clamped");
  reset_loc_a: assert property (key_go && key == `SST_K_RESET |=> loc_reg == '0 && !ent_act_reg)
    else $error("reset key did not return to location 1");
  reset_out_a: assert property (key_go && key == `SST_K_RESET && operate_reg
                                |=> ##1 out_sp == sp_mem[0])
    else $error("output did not follow location 1");
  sp_round_a: assert property (cm_sp_reg |-> cm_spv_reg.mant % 17'd5 == 17'h0)
    else $error("setpoint not rounded");
  vl_range_a: assert property (cm_vl_reg |-> cm_val_reg >= 24'd1 && cm_val_reg <= 24'd105)
    else $error("compliance out of range stored");
  dw_range_a: assert property (cm_dw_reg |-> cm_val_reg == 24'h0
                               || (cm_val_reg >= 24'd3 && cm_val_reg <= 24'd999900))
    else $error("hold interval out of range stored");
  trig_len_a: assert property ($rose(trig_out_n_reg) |-> $past(low_len_reg) == 16'(TRIG_CYC))
    else $error("trigger pulse length wrong");
  mode_lamp_a: assert property (phase_reg == PH_READY |=> lamp.step == $past(mode_reg == PM_STEP)
                                && lamp.run == $past(run_reg))
    else $error("mode lamp mismatch");
  ext_start_a: assert property (trig_fire_reg && phase_reg == PH_READY && !run_reg
                                && !key_go && !cm_loc_reg |=> run_reg)
    else $error("external trigger did not start");
  run_cv: cover property (run_reg && mode_reg == PM_CONT && loc_reg == '0 ##1 $changed(loc_reg));
  err_cv: cover property ($rose(err_on));
  trig_cv: cover property ($fell(trig_out_n_reg));
  oper_cv: cover property (operate_reg && out_sp != '0);
endmodule // sst_sequencer
`default_nettype wire

//--- sst_consts.svh
/*
  Constants of the stored setpoint sequencer: register offsets, key codes,
  limits, reset values and times. Assumes a 20 MHz clock and 32-bit Wishbone.
*/
`ifndef SST_CONSTS_SVH
`define SST_CONSTS_SVH
// Contract
// - One hundred locations, each with its own setpoint, compliance and hold interval.
// - Reset key returns the pointer to location 1; output follows at once.
// - Reset key drops an uncommitted entry and restores the shown value.
// - Setpoint commit rounds last digit down: 1-4 to 0, 6-9 to 5.
// - Pressing the edited parameter's own key abandons the entry.
// - Compliance takes whole volts 1 to 105, shown right-justified.
// - Hold interval 3 ms to 999.9 s, normalised to exponent -3 or 0.
// - Zero hold beyond location 1 wraps in step and loop, stops one-pass.
// - Exponent key works only for setpoint or hold; commit renormalises.
// - Only the commit key stores an edited value into the present location.
// - Copy key duplicates the present location into the next, memory view only.
// - Operate key toggles output; when off the output setpoint is zero.
// - Outside operate, compliance above 32 V is clamped internally to 32 V.
// - Step mode advances on each run key press; step lamp lit.
// - One-pass mode walks the locations once; its lamp lit.
// - Looping mode walks the locations until stopped; its lamp lit.
// - One-pass and looping modes stay each location's hold interval.
// - Run key alternates between start and stop; in step mode a press during the hold is ignored.
// - Run lamp lit while running; in step mode only during the hold.
// - Location contents are volatile and restart from defaults.
// - Power-up lamp test, then revision and bus address about one second each.
// - External trigger low for 10 us starts the run like the run key.
// - Each hold end gives an active-low trigger pulse longer than 10 us.
// - Out-of-range entry is not stored; error shown about one second.
`define SST_KEY_OFS 8'h00
`define SST_DISP_OFS 8'h04
`define SST_OUT_OFS 8'h08
`define SST_LOC_OFS 8'h0c
`define SST_K_DOT 5'h0a
`define SST_K_MINUS 5'h0b
`define SST_K_SRC 5'h0c
`define SST_K_MEM 5'h0f
`define SST_K_EXP 5'h10
`define SST_K_ENTER 5'h11
`define SST_K_COPY 5'h12
`define SST_K_OPER 5'h13
`define SST_K_STEP 5'h14
`define SST_K_SINGLE 5'h15
`define SST_K_CONT 5'h16
`define SST_K_RESET 5'h17
`define SST_K_RUN 5'h18
`define SST_MANT_HI 24'h004e1f
`define SST_MANT_LO 24'h0007d0
`define SST_SP_MAX 24'h002774
`define SST_SP_EXP_TOP (-6'sd5)
`define SST_VL_MAX 24'h000069
`define SST_VL_CLAMP 7'h20
`define SST_DW_MIN 24'h000003
`define SST_DW_MAX 24'h0f41dc
`define SST_DW_EXP (-6'sd3)
`define SST_VL_RST 7'h01
`define SST_DW1_RST 20'h00003
`define SST_CLK_KHZ 20000
`define SST_TEST_MS 3000
`define SST_SHOW_MS 1000
`define SST_TRIG_US 10
`endif

//--- sst_pkg.sv
/*
  Types of the stored setpoint sequencer: modes, phases and carriers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package sst_pkg;
  typedef enum logic [1:0] {DM_SRC, DM_VLIM, DM_DWELL, DM_MEM} sst_disp_t;
  typedef enum logic [1:0] {PM_STEP, PM_SINGLE, PM_CONT} sst_pmode_t;
  typedef enum logic [1:0] {PH_TEST, PH_REV, PH_ADDR, PH_READY} sst_phase_t;
  typedef enum logic [1:0] {NM_IDLE, NM_SP, NM_DW} sst_norm_t;
  typedef struct packed {
    logic neg;
    logic signed [5:0] exp;
    logic [16:0] mant;
  } sst_sp_t;
  typedef struct packed {
    logic operate;
    logic step;
    logic single;
    logic cont;
    logic run;
    logic err;
  } sst_lamp_t;
endpackage
`default_nettype wire

//--- sst_opmodel.sv
/*
  Operator side model: drives the external trigger pin.
  Assumes the pin idles high on a pull-up.
*/
`timescale 1ns/100ps
`default_nettype none
module sst_opmodel (
  input wire logic mclk,
  output logic trig_n
);
  // Pin idles high on its pull-up
  initial trig_n = 1'b1;
  // Low pulse held well past the minimum width
  task fire(input int cyc_low);
    @(posedge mclk);
    trig_n <= 1'b0;
    repeat (cyc_low) @(posedge mclk);
    trig_n <= 1'b1;
  endtask
endmodule // sst_opmodel
`default_nettype wire

//--- testbench.sv
/*
  Self-checking bench of the setpoint sequencer, keys sent over Wishbone.
  Assumes the operator model drives the trigger pin.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sst_consts.svh"
module testbench;
  import sst_pkg::*;
  logic mclk, rstn, cyc, stb, we, ack, trig_in_n, trig_out_n;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rd, q;
  logic [6:0] out_vl;
  sst_sp_t out_sp, exp_sp;
  sst_lamp_t lamp;
  int err_total, samples_checked, v, d, n;
  sst_sequencer #(.TEST_CYC(50), .SHOW_CYC(20), .MS_CYC(100)) sst_sequencer_i (.mclk(mclk),
    .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .ext_trig_in_n(trig_in_n), .ext_trig_out_n(trig_out_n), .out_sp(out_sp),
    .out_vl(out_vl), .lamp(lamp));
  sst_opmodel sst_opmodel_i (.mclk(mclk), .trig_n(trig_in_n));
  // Clock source
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Verdict and end of run
  task close_out;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Compare seen against expected
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  // One classic bus cycle, held until ack
  task wb(input logic w_en, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_en;
    sel <= 4'hf;
    adr <= a;
    dat <= wd;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (ack !== 1'b1 && k < 40);
    if (ack !== 1'b1)
    begin
      err_total++;
      close_out();
    end
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task key(input int c);
    wb(1'b1, 8'h00, 32'(c));
  endtask
  task rdr(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  // Poll until ready, idle and the masked lamps off
  task settle(input logic [13:0] m = 14'h3801);
    int k;
    k = 0;
    do
    begin
      rdr(8'h00);
      k++;
    end
    while ((q[13:0] & m) !== 14'h3000 && k < 400);
    if ((q[13:0] & m) !== 14'h3000)
    begin
      err_total++;
      close_out();
    end
  endtask
  // Main sequence
  initial
  begin
    {rstn, cyc, stb, we, sel, adr, dat} = '0;
    v = $urandom(2385);
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rdr(8'h00);
    chk(q[13:12], 0);
    chk(out_vl, `SST_VL_RST);
    settle;
    v = 33 + $urandom % 73;
    key(13); key(v / 100); key(v / 10 % 10); key(v % 10); key(`SST_K_ENTER);
    settle;
    rdr(8'h0c);
    chk(q[22:16], `SST_VL_CLAMP);
    rdr(8'h04);
    chk(q, v);
    key(13); key(5); key(13);
    rdr(8'h04);
    chk(q, v);
    key(13); key(1); key(0); key(6); key(`SST_K_ENTER);
    rdr(8'h00);
    chk(q[0], 1);
    settle;
    rdr(8'h04);
    chk(q, v);
    key(`SST_K_OPER);
    settle;
    rdr(8'h0c);
    chk(q[22:16], v);
    d = $urandom % 10;
    exp_sp = '{neg: 1'b0, exp: -6'sd9, mant: 17'(12340 + (d >= 5 ? 5 : 0))};
    key(`SST_K_SRC); key(1); key(2); key(3); key(4); key(d);
    key(`SST_K_EXP); key(`SST_K_MINUS); key(9); key(`SST_K_ENTER);
    settle;
    rdr(8'h08);
    chk(q, {8'h0, exp_sp});
    rdr(8'h10);
    chk(q, 0);
    key(`SST_K_MEM); key(`SST_K_COPY);
    fork
      sst_opmodel_i.fire(250);
      begin
        n = 0;
        while (trig_out_n !== 1'b0 && n < 900) @(negedge mclk) n++;
        n = 0;
        while (trig_out_n === 1'b0 && n < 400) @(negedge mclk) n++;
      end
    join
    chk(n, 201);
    rdr(8'h0c);
    chk(q[7:0], 2);
    rdr(8'h08);
    chk(q, {8'h0, exp_sp});
    key(`SST_K_SRC); key(0); key(`SST_K_ENTER);
    settle;
    rdr(8'h08);
    chk(q, 0);
    key(7); key(`SST_K_RESET);
    rdr(8'h0c);
    chk(q[7:0], 1);
    rdr(8'h08);
    chk(q, {8'h0, exp_sp});
    rdr(8'h04);
    chk(q, {8'h0, exp_sp});
    key(`SST_K_SINGLE); key(`SST_K_RUN);
    settle(14'h3803);
    chk(q[3], 1);
    rdr(8'h0c);
    chk(q[7:0], 2);
    close_out();
  end
endmodule // testbench
`default_nettype wire
